// ---- msc_consts.svh ----
// Constants for the motor starter control block: setting locations, codes and timing.
// Assumes a 50 MHz system clock; included by bare name wherever needed.
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

`define MSC_LOC_BAUD 16'h1139
`define MSC_LOC_PARITY 16'h1147
`define MSC_BAUD_9600 16'h0003
`define MSC_BAUD_19200 16'h0004
`define MSC_PARITY_NONE 16'h0000
`define MSC_PARITY_EVEN 16'h0001
`define MSC_PARITY_ODD 16'h0002
`define MSC_DATA_BITS 4'h8
`define MSC_STOP_BITS 2'h1
`define MSC_CLK_HZ 50000000
`define MSC_TICK_NS 1000000
`define MSC_CLK_NS 20
`define MSC_FEEDBACK_MS 1000
`define MSC_ADDR_WINDOW_MIN 5
`define MSC_SLAVE_ADDR_RESET 8'h00

`endif

// ---- msc_pkg.sv ----
// Types shared by the motor starter control block.
// Assumes nothing of its surroundings.
package msc_pkg;

    // Run sequencer states, one-hot.
    typedef enum logic [3:0] {
        MSC_ST_STOPPED = 4'h1,
        MSC_ST_RUNNING = 4'h2,
        MSC_ST_TRIPPED = 4'h4,
        MSC_ST_FAULT = 4'h8
    } msc_state_t;

    // Control scheme selection.
    typedef enum logic [1:0] {
        MSC_MODE_TWO_WIRE = 2'h0,
        MSC_MODE_HAND_AUTO_2W = 2'h1,
        MSC_MODE_HAND3_AUTO2 = 2'h2
    } msc_mode_t;

endpackage

// ---- msc_input_sync.sv ----
// Three-stage synchroniser with agreement filter for field inputs.
// Assumes asynchronous inputs; the output changes only when stages two and three agree.
`timescale 1ns/100ps
module msc_input_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [WIDTH-1:0] din, // Raw pin levels.
    output logic [WIDTH-1:0] dout // Filtered levels.
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // Each bit has its own chain; the first stage feeds only the second.
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                s1_r[i] <= 1'b0;
                s2_r[i] <= 1'b0;
                s3_r[i] <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                s1_r[i] <= din[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// ---- msc_tick.sv ----
// Prescaler giving a one-cycle tick every DIV clock cycles.
// Assumes a free-running system clock.
`timescale 1ns/100ps
module msc_tick #(
    parameter int DIV = 50000
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    output logic tick // One-cycle pulse.
);
    logic [31:0] cnt_r;

    if (DIV < 2) begin : g_chk
        $error("msc_tick: DIV must be at least 2");
    end

    // Counting down keeps the compare against a constant zero.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == 32'h0) begin
            cnt_r <= 32'(DIV - 1);
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// ---- msc_top.sv ----
// Start/stop sequencing of a motor starter with a small serial setting bank.
// Assumes field contacts on pins and a serial front end that decodes setting
// writes and address-assign commands into the strobes below.
//
// Overview of operation
// - Power-up format is 9600 baud, no parity.
// - Default character is eight data, one stop.
// - Location 1139 holds baud; 4 selects 19200.
// - Location 1147 holds parity; 1 selects even.
// - Format writes take effect immediately.
// - Address assignment accepted only first five minutes.
// - Two-wire: run while start contact closed.
// - Faceplate stop latches trip until reset.
// - No start while stop input open.
// - Stop input open reports motor unavailable.
// - Feedback missing one second raises alarm.
// - Feedback alarm opens the contactor output.
// - Hand position energizes contactor immediately.
// - Off position keeps contactor de-energized.
// - Auto follows the process contact.
// - Reset restarts if maintained start present.
// - Three-wire hand: start and stop buttons.
// - Any of ten inputs drives two-wire.
`timescale 1ns/100ps
`include "msc_consts.svh"
module msc_top
    import msc_pkg::*;
#(
    parameter int N_PROG = 10,
    parameter int TICK_CYCLES = (`MSC_TICK_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS,
    parameter int FEEDBACK_TICKS = `MSC_FEEDBACK_MS,
    parameter int ADDR_WINDOW_TICKS = `MSC_ADDR_WINDOW_MIN * 60 * 1000
) (
    input wire logic clock, // System clock, 50 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [N_PROG-1:0] prog_in, // Programmable input pins, bit 0 is programmable_input_one.
    input wire logic [3:0] two_wire_sel, // Which programmable input is the two-wire contact.
    input wire logic [1:0] control_mode, // Control scheme, msc_mode_t.
    input wire logic sel_hand, // Selector in hand.
    input wire logic sel_auto, // Selector in auto; neither means off.
    input wire logic start_button, // Three-wire start pushbutton, closed high.
    input wire logic stop_button, // Three-wire stop pushbutton, pressed high.
    input wire logic stop_input, // Stop permissive contact, closed high.
    input wire logic contactor_status, // Contactor auxiliary feedback, closed high.
    input wire logic key_stop, // Faceplate stop key, pressed high.
    input wire logic key_reset, // Faceplate reset key, pressed high.
    input wire logic set_wr, // Setting write strobe.
    input wire logic [15:0] set_loc, // Setting location.
    input wire logic [15:0] set_wdata, // Setting write value.
    output logic [15:0] set_rdata, // Setting read value at set_loc.
    input wire logic addr_cmd, // Address-assign command strobe.
    input wire logic [7:0] addr_value, // New slave address.
    output logic [7:0] slave_addr, // Current slave address.
    output logic addr_window_open, // Address assignment still allowed.
    output logic [15:0] baud_code, // Serial baud rate code.
    output logic [15:0] parity_code, // Serial parity code.
    output logic [3:0] data_bits, // Serial data bits.
    output logic [1:0] stop_bits, // Serial stop bits.
    output logic format_changed, // One-cycle pulse on a format write.
    output logic contactor_out, // Contactor coil drive, high energizes.
    output logic motor_unavailable, // Stop input open.
    output logic trip_latched, // Faceplate stop trip latched.
    output logic feedback_missing_alarm // Contactor feedback did not confirm.
);
    localparam int NSYNC = 8;

    if (N_PROG < 1 || N_PROG > 16 || FEEDBACK_TICKS < 1 || ADDR_WINDOW_TICKS < 1) begin : g_chk
        $error("msc_top: parameter out of range");
    end

    logic tick;
    logic [NSYNC-1:0] raw_pins;
    logic [NSYNC-1:0] pins;
    logic [N_PROG-1:0] prog_s;
    logic hand_s, auto_s, start_s, stopb_s, permit_s, fb_s, kstop_s, kreset_s;
    logic start_d_r, kstop_d_r, kreset_d_r;
    logic start_rise, kstop_rise, kreset_rise;
    logic hand_latch_r;
    logic demand;
    logic two_wire_contact;
    logic [31:0] fb_cnt_r;
    logic [31:0] win_cnt_r;
    logic fb_expired;
    msc_state_t state_r, state_nxt;

    assign raw_pins = {sel_hand, sel_auto, start_button, stop_button,
                       stop_input, contactor_status, key_stop, key_reset};

    msc_input_sync #(.WIDTH(NSYNC)) u_sync_pins (
        .clock(clock),
        .rst(rst),
        .din(raw_pins),
        .dout(pins)
    );

    msc_input_sync #(.WIDTH(N_PROG)) u_sync_prog (
        .clock(clock),
        .rst(rst),
        .din(prog_in),
        .dout(prog_s)
    );

    msc_tick #(.DIV(TICK_CYCLES)) u_tick (
        .clock(clock),
        .rst(rst),
        .tick(tick)
    );

    assign {hand_s, auto_s, start_s, stopb_s, permit_s, fb_s, kstop_s, kreset_s} = pins;

    // Edge detection on keys so a held key acts once.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_d_r <= 1'b0;
            kstop_d_r <= 1'b0;
            kreset_d_r <= 1'b0;
        end else begin
            start_d_r <= start_s;
            kstop_d_r <= kstop_s;
            kreset_d_r <= kreset_s;
        end
    end

    assign start_rise = start_s & ~start_d_r;
    assign kstop_rise = kstop_s & ~kstop_d_r;
    assign kreset_rise = kreset_s & ~kreset_d_r;

    // selectable two-wire input; out-of-range selection reads open.
    always_comb begin
        two_wire_contact = 1'b0;
        if (int'(two_wire_sel) < N_PROG) begin
            two_wire_contact = prog_s[two_wire_sel];
        end
    end

    // three-wire seal-in
    // The stop button wins over start; leaving hand or any trip drops the seal-in.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hand_latch_r <= 1'b0;
        end else if (stopb_s || !hand_s || !permit_s || (state_r != MSC_ST_STOPPED &&
                     state_r != MSC_ST_RUNNING) || kstop_rise) begin
            hand_latch_r <= 1'b0;
        end else if (start_rise) begin
            hand_latch_r <= 1'b1;
        end
    end

    // Run demand from the selected control scheme.
    always_comb begin
        demand = 1'b0;
        case (msc_mode_t'(control_mode))
            MSC_MODE_TWO_WIRE: demand = two_wire_contact;
            MSC_MODE_HAND_AUTO_2W: begin
                // hand runs, off stops, auto follows contact
                if (hand_s) begin
                    demand = 1'b1;
                end else if (auto_s) begin
                    demand = two_wire_contact;
                end
            end
            MSC_MODE_HAND3_AUTO2: begin
                if (hand_s) begin
                    demand = hand_latch_r;
                end else if (auto_s) begin
                    demand = two_wire_contact;
                end
            end
            default: demand = 1'b0;
        endcase
    end

    // timer only runs while the coil is commanded closed.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fb_cnt_r <= 32'h0;
        end else if (!contactor_out || fb_s) begin
            fb_cnt_r <= 32'h0;
        end else if (tick && !fb_expired) begin
            fb_cnt_r <= fb_cnt_r + 32'h1;
        end
    end

    assign fb_expired = (fb_cnt_r >= 32'(FEEDBACK_TICKS));

    // Sequencer: next state.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MSC_ST_STOPPED: begin
                if (kstop_rise) begin
                    state_nxt = MSC_ST_TRIPPED;
                end else if (demand && permit_s) begin
                    state_nxt = MSC_ST_RUNNING;
                end
            end
            MSC_ST_RUNNING: begin
                if (kstop_rise) begin
                    state_nxt = MSC_ST_TRIPPED;
                end else if (fb_expired) begin
                    state_nxt = MSC_ST_FAULT;
                end else if (!demand || !permit_s) begin
                    state_nxt = MSC_ST_STOPPED;
                end
            end
            MSC_ST_TRIPPED: begin
                // reset returns to stopped; a held start restarts next cycle
                if (kreset_rise && !kstop_s) begin
                    state_nxt = MSC_ST_STOPPED;
                end
            end
            MSC_ST_FAULT: begin
                if (kstop_rise) begin
                    state_nxt = MSC_ST_TRIPPED;
                end else if (kreset_rise) begin
                    state_nxt = MSC_ST_STOPPED;
                end
            end
            default: state_nxt = MSC_ST_STOPPED;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= MSC_ST_STOPPED;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Contactor, trip and alarm outputs are registered from the next state so they track it exactly; motor_unavailable is registered from the permissive.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            contactor_out <= 1'b0;
            trip_latched <= 1'b0;
            feedback_missing_alarm <= 1'b0;
            motor_unavailable <= 1'b0;
        end else begin
            contactor_out <= (state_nxt == MSC_ST_RUNNING);
            trip_latched <= (state_nxt == MSC_ST_TRIPPED);
            feedback_missing_alarm <= (state_nxt == MSC_ST_FAULT);
            motor_unavailable <= ~permit_s;
        end
    end

    // address window timer
    // Saturates so the window never reopens without a power cycle.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            win_cnt_r <= 32'h0;
            addr_window_open <= 1'b1;
        end else begin
            if (tick && addr_window_open) begin
                win_cnt_r <= win_cnt_r + 32'h1;
            end
            addr_window_open <= (win_cnt_r < 32'(ADDR_WINDOW_TICKS));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            slave_addr <= `MSC_SLAVE_ADDR_RESET;
        end else if (addr_cmd && addr_window_open) begin
            slave_addr <= addr_value;
        end
    end

    // Serial format settings; any written value is stored, the front end decodes it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            baud_code <= `MSC_BAUD_9600;
            parity_code <= `MSC_PARITY_NONE;
            data_bits <= `MSC_DATA_BITS;
            stop_bits <= `MSC_STOP_BITS;
            format_changed <= 1'b0;
        end else begin
            data_bits <= `MSC_DATA_BITS;
            stop_bits <= `MSC_STOP_BITS;
            format_changed <= 1'b0;
            if (set_wr) begin
                case (set_loc)
                    `MSC_LOC_BAUD: begin
                        baud_code <= set_wdata;
                        format_changed <= 1'b1;
                    end
                    `MSC_LOC_PARITY: begin
                        parity_code <= set_wdata;
                        format_changed <= 1'b1;
                    end
                    default: format_changed <= 1'b0;
                endcase
            end
        end
    end

    // Read-back of the setting bank; unknown locations read zero.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            set_rdata <= 16'h0000;
        end else begin
            case (set_loc)
                `MSC_LOC_BAUD: set_rdata <= baud_code;
                `MSC_LOC_PARITY: set_rdata <= parity_code;
                default: set_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// ---- msc_top_sva.sv ----
// Checker for the motor starter control top level.
// Assumes it is bound into msc_top and sees only its ports.
`timescale 1ns/100ps
module msc_top_sva #(
    parameter int N_PROG = 10,
    parameter int TICK_CYCLES = 4,
    parameter int FEEDBACK_TICKS = 10,
    parameter int ADDR_WINDOW_TICKS = 50
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Reset, active high.
    input wire logic stop_input, // Stop permissive.
    input wire logic contactor_status, // Feedback pin.
    input wire logic set_wr, // Setting strobe.
    input wire logic [15:0] set_loc, // Setting location.
    input wire logic [15:0] set_wdata, // Setting value.
    input wire logic addr_cmd, // Address strobe.
    input wire logic [7:0] addr_value, // New address.
    input wire logic [7:0] slave_addr, // Current address.
    input wire logic addr_window_open, // Window flag.
    input wire logic [15:0] baud_code, // Baud code.
    input wire logic [15:0] parity_code, // Parity code.
    input wire logic [3:0] data_bits, // Data bits.
    input wire logic [1:0] stop_bits, // Stop bits.
    input wire logic format_changed, // Format pulse.
    input wire logic contactor_out, // Coil drive.
    input wire logic motor_unavailable, // Permissive lost.
    input wire logic trip_latched, // Stop trip.
    input wire logic feedback_missing_alarm // Feedback alarm.
);
    localparam int FB_MIN = (FEEDBACK_TICKS - 1) * TICK_CYCLES;
    localparam int FB_MAX = (FEEDBACK_TICKS + 2) * TICK_CYCLES + 8;
    localparam longint W_MIN = longint'(ADDR_WINDOW_TICKS - 1) * TICK_CYCLES;
    localparam longint W_MAX = longint'(ADDR_WINDOW_TICKS + 1) * TICK_CYCLES + 2;
    int up_cnt;
    int nofb_cnt;
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Cycles since reset release; saturates so the run length cannot wrap it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            up_cnt <= 0;
        end else if (up_cnt < 100000) begin
            up_cnt <= up_cnt + 1;
        end
    end

    // Cycles with the coil driven but no feedback at the pin.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nofb_cnt <= 0;
        end else begin
            nofb_cnt <= (contactor_out && !contactor_status) ? nofb_cnt + 1 : 0;
        end
    end

    a_baud_write: assert property (set_wr && set_loc == 16'h1139 |=>
        baud_code == $past(set_wdata) && format_changed) else $error("baud write lost");
    a_parity_write: assert property (set_wr && set_loc == 16'h1147 |=>
        parity_code == $past(set_wdata) && format_changed) else $error("parity write lost");
    a_char_format: assert property (data_bits == 4'h8 && stop_bits == 2'h1)
        else $error("character format wrong");
    a_addr_taken: assert property (addr_cmd && addr_window_open |=>
        slave_addr == $past(addr_value)) else $error("address not taken");
    a_addr_refused: assert property (addr_cmd && !addr_window_open |=>
        $stable(slave_addr)) else $error("late address taken");
    a_window_span: assert property (up_cnt < W_MIN ? addr_window_open :
        (up_cnt > W_MAX ? !addr_window_open : 1'b1)) else $error("window length wrong");
    a_stop_blocks: assert property (motor_unavailable [*3] |-> !contactor_out)
        else $error("run without permissive");
    a_unavail_flag: assert property (!stop_input [*8] |-> motor_unavailable)
        else $error("unavailable not shown");
    a_trip_opens: assert property (trip_latched [*2] |-> !contactor_out)
        else $error("coil on while tripped");
    a_alarm_opens: assert property (feedback_missing_alarm [*2] |-> !contactor_out)
        else $error("coil on with alarm");
    a_alarm_late: assert property (nofb_cnt > FB_MAX |-> feedback_missing_alarm)
        else $error("alarm too late");
    a_alarm_early: assert property ($rose(feedback_missing_alarm) |-> nofb_cnt >= FB_MIN)
        else $error("alarm too early");
endmodule

bind msc_top msc_top_sva #(.N_PROG(N_PROG), .TICK_CYCLES(TICK_CYCLES),
    .FEEDBACK_TICKS(FEEDBACK_TICKS), .ADDR_WINDOW_TICKS(ADDR_WINDOW_TICKS)) u_sva (
    .clock(clock), .rst(rst), .stop_input(stop_input), .contactor_status(contactor_status),
    .set_wr(set_wr), .set_loc(set_loc), .set_wdata(set_wdata), .addr_cmd(addr_cmd),
    .addr_value(addr_value), .slave_addr(slave_addr), .addr_window_open(addr_window_open),
    .baud_code(baud_code), .parity_code(parity_code), .data_bits(data_bits),
    .stop_bits(stop_bits), .format_changed(format_changed), .contactor_out(contactor_out),
    .motor_unavailable(motor_unavailable), .trip_latched(trip_latched),
    .feedback_missing_alarm(feedback_missing_alarm));

// ---- msc_field_model.sv ----
// Contactor with an auxiliary feedback contact, driven by the coil output.
// Assumes the bench lowers fb_ok to model a broken control circuit.
`timescale 1ns/100ps
module msc_field_model (
    input wire logic clock, // System clock.
    input wire logic coil, // Coil drive from the block.
    input wire logic fb_ok, // Low breaks the feedback circuit.
    output logic contactor_status // Auxiliary contact, closed high.
);
    logic [2:0] pick_r = 3'h0;

    // The armature picks up a few cycles after the coil, well inside the supervision time.
    // prompt feedback
    always @(posedge clock) begin
        pick_r <= {pick_r[1:0], coil};
    end
    assign contactor_status = fb_ok & pick_r[2];
endmodule

// ---- tb_msc_top.sv ----
// Self-checking bench for the motor starter control block.
// Assumes shortened timer parameters; a contactor model answers the coil.
`timescale 1ns/100ps
module tb_msc_top
    import msc_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [9:0] prog_in = 10'h000;
    logic [3:0] two_wire_sel = 4'h9;
    logic [1:0] control_mode = MSC_MODE_TWO_WIRE;
    logic sel_hand = 1'b0, sel_auto = 1'b0, start_button = 1'b0, stop_button = 1'b0;
    logic stop_input = 1'b1, key_stop = 1'b0, key_reset = 1'b0, fb_ok = 1'b1;
    logic set_wr = 1'b0, addr_cmd = 1'b0;
    logic [15:0] set_loc = 16'h0000, set_wdata = 16'h0000;
    logic [7:0] addr_value = 8'h00;
    logic [15:0] set_rdata, baud_code, parity_code;
    logic [7:0] slave_addr;
    logic [3:0] data_bits;
    logic [1:0] stop_bits;
    logic addr_window_open, format_changed, contactor_out, motor_unavailable;
    logic trip_latched, feedback_missing_alarm, contactor_status;
    int err_total = 0;
    int checked = 0;

    always #10 clock = ~clock;

    msc_top #(.N_PROG(10), .TICK_CYCLES(4), .FEEDBACK_TICKS(10), .ADDR_WINDOW_TICKS(50)) u_dut (
        .clock(clock), .rst(rst), .prog_in(prog_in), .two_wire_sel(two_wire_sel),
        .control_mode(control_mode), .sel_hand(sel_hand), .sel_auto(sel_auto),
        .start_button(start_button), .stop_button(stop_button), .stop_input(stop_input),
        .contactor_status(contactor_status), .key_stop(key_stop), .key_reset(key_reset),
        .set_wr(set_wr), .set_loc(set_loc), .set_wdata(set_wdata), .set_rdata(set_rdata),
        .addr_cmd(addr_cmd), .addr_value(addr_value), .slave_addr(slave_addr),
        .addr_window_open(addr_window_open), .baud_code(baud_code), .parity_code(parity_code),
        .data_bits(data_bits), .stop_bits(stop_bits), .format_changed(format_changed),
        .contactor_out(contactor_out), .motor_unavailable(motor_unavailable),
        .trip_latched(trip_latched), .feedback_missing_alarm(feedback_missing_alarm));

    msc_field_model u_field (.clock(clock), .coil(contactor_out), .fb_ok(fb_ok),
        .contactor_status(contactor_status));

    task automatic print_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    function automatic logic sel_sig(input int which);
        return which == 0 ? contactor_out : which == 1 ? feedback_missing_alarm : addr_window_open;
    endfunction

    // Bounded wait; a wait that runs out ends the run at once.
    task automatic wait_sig(input int which, input logic e);
        int i;
        for (i = 0; i < 300 && sel_sig(which) !== e; i++) begin
            cyc(1);
        end
        if (i == 300) begin
            err_total++;
            print_verdict();
        end
        chk("waited signal", sel_sig(which), e);
    endtask

    // Keys are held long enough to pass the input filter: 0 stop, 1 reset, 2 start, 3 stop button.
    task automatic press(input int k);
        {stop_button, start_button, key_reset, key_stop} = 4'h1 << k;
        cyc(8);
        {stop_button, start_button, key_reset, key_stop} = 4'h0;
        cyc(8);
    endtask

    task automatic wr(input logic [15:0] loc, input logic [15:0] val);
        set_wr = 1'b1;
        set_loc = loc;
        set_wdata = val;
        cyc(1);
        set_wr = 1'b0;
    endtask

    task automatic t_addr(input logic [7:0] val, input logic [7:0] exp);
        addr_value = val;
        addr_cmd = 1'b1;
        cyc(1);
        addr_cmd = 1'b0;
        chk("slave_addr", slave_addr, exp);
    endtask

    task automatic t_defaults();
        chk("baud_code", baud_code, 16'h0003);
        chk("parity_code", parity_code, 16'h0000);
        chk("data_bits", data_bits, 4'h8);
        chk("stop_bits", stop_bits, 2'h1);
        chk("slave_addr", slave_addr, 8'h00);
    endtask

    task automatic t_format();
        wr(16'h1139, 16'h0004);
        chk("format_changed", format_changed, 1'b1);
        chk("baud_code", baud_code, 16'h0004);
        cyc(1);
        chk("format_changed", format_changed, 1'b0);
        chk("set_rdata", set_rdata, 16'h0004);
        wr(16'h1147, 16'h0001);
        chk("parity_code", parity_code, 16'h0001);
        cyc(1);
        chk("set_rdata", set_rdata, 16'h0001);
        wr(16'h1140, 16'h0007);
        chk("format_changed", format_changed, 1'b0);
        cyc(1);
        chk("set_rdata", set_rdata, 16'h0000);
        chk("baud_code", baud_code, 16'h0004);
    endtask

    task automatic t_two_wire();
        prog_in = 10'h001;
        cyc(12);
        chk("contactor_out", contactor_out, 1'b0);
        prog_in = 10'h200;
        wait_sig(0, 1'b1);
        cyc(60);
        chk("contactor_out", contactor_out, 1'b1);
        prog_in = 10'h000;
        wait_sig(0, 1'b0);
    endtask

    task automatic t_permissive();
        stop_input = 1'b0;
        prog_in = 10'h200;
        cyc(20);
        chk("contactor_out", contactor_out, 1'b0);
        chk("motor_unavailable", motor_unavailable, 1'b1);
        stop_input = 1'b1;
        wait_sig(0, 1'b1);
        chk("motor_unavailable", motor_unavailable, 1'b0);
    endtask

    task automatic t_trip();
        press(0);
        chk("trip_latched", trip_latched, 1'b1);
        chk("contactor_out", contactor_out, 1'b0);
        cyc(10);
        chk("contactor_out", contactor_out, 1'b0);
        press(1);
        chk("trip_latched", trip_latched, 1'b0);
        wait_sig(0, 1'b1);
        prog_in = 10'h000;
        wait_sig(0, 1'b0);
        press(0);
        press(1);
        cyc(12);
        chk("contactor_out", contactor_out, 1'b0);
    endtask

    task automatic t_feedback();
        fb_ok = 1'b0;
        prog_in = 10'h200;
        wait_sig(0, 1'b1);
        wait_sig(1, 1'b1);
        cyc(3);
        chk("contactor_out", contactor_out, 1'b0);
        prog_in = 10'h000;
        fb_ok = 1'b1;
        press(1);
        chk("feedback_missing_alarm", feedback_missing_alarm, 1'b0);
    endtask

    task automatic t_hand_auto();
        control_mode = MSC_MODE_HAND_AUTO_2W;
        sel_hand = 1'b1;
        cyc(10);
        chk("contactor_out", contactor_out, 1'b1);
        sel_hand = 1'b0;
        prog_in = 10'h200;
        wait_sig(0, 1'b0);
        cyc(12);
        chk("contactor_out", contactor_out, 1'b0);
        sel_auto = 1'b1;
        wait_sig(0, 1'b1);
        prog_in = 10'h000;
        wait_sig(0, 1'b0);
        sel_auto = 1'b0;
    endtask

    task automatic t_three_wire();
        control_mode = MSC_MODE_HAND3_AUTO2;
        sel_hand = 1'b1;
        cyc(12);
        chk("contactor_out", contactor_out, 1'b0);
        press(2);
        chk("contactor_out", contactor_out, 1'b1);
        press(3);
        chk("contactor_out", contactor_out, 1'b0);
        sel_hand = 1'b0;
        sel_auto = 1'b1;
        prog_in = 10'h200;
        wait_sig(0, 1'b1);
        stop_input = 1'b0;
        wait_sig(0, 1'b0);
        chk("motor_unavailable", motor_unavailable, 1'b1);
        prog_in = 10'h000;
        stop_input = 1'b1;
        sel_auto = 1'b0;
    endtask

    // Main sequence; the late address command waits until the address window has closed.
    initial begin
        cyc(10);
        rst = 1'b0;
        cyc(1);
        t_defaults();
        t_format();
        t_addr(8'h5A, 8'h5A);
        t_two_wire();
        t_permissive();
        t_trip();
        t_feedback();
        t_hand_auto();
        t_three_wire();
        wait_sig(2, 1'b0);
        t_addr(8'h33, 8'h5A);
        print_verdict();
    end
endmodule
